// ---- logic/artx_sequencer.sv ----
// Auto-retransmit transmit sequencer with CSMA retry and reply wait
// How it works
// RULE1: Host enters mode via command field
// RULE2: Host configures and loads buffer first
// RULE3: Start on trigger rise or start command
// RULE4: Channel access, then send on idle
// RULE5: Busy after retry limit gives code 3
// RULE6: Bit 5 of octet one requests reply
// RULE7: No reply requested: success at end
// RULE8: Accept only matching, FCS-correct reply
// RULE9: Reply gives 0, or 1 if pending
// RULE10: Timeout retries; past limit code 5
// RULE11: Buffer untouched; other frames dropped
// RULE12: Codes 0,1,3,5,7 valid after interrupt
// RULE13: Limit 7 sends once without access
// RULE14: Timeout 120 BPSK, 54 O-QPSK symbols
// RULE15: Timeout counted in header symbols
// RULE16: Zero exponent gives eight-symbol access
// RULE17: Code waiting-for-reply while listening
// RULE18: Status busy during transaction, then idle
// RULE19: Interrupts gated by mask
// RULE20: Listen mode start, match, end events
// RULE21: Lock interrupt when entered from off
// RULE22: Suppress CCA, start, match during retransmit
// RULE23: Code 7 when a procedure starts
// RULE24: Clear retry counters at their starts
`timescale 1ns/1ps
`default_nettype none
module artx_sequencer #(
  parameter int SYM_CYCLES = 320,
  parameter int BO_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Host command and configuration
  input wire logic [4:0] state_command_field_i,
  input wire logic cmd_write_i,
  input wire logic sleep_trigger_pin_i,
  input wire logic [2:0] channel_access_retry_limit_i,
  input wire logic [3:0] frame_retry_limit_i,
  input wire logic [3:0] min_backoff_exponent_i,
  input wire logic bpsk_mode_i,
  input wire logic [7:0] irq_mask_i,
  // Radio side
  input wire logic [7:0] first_octet_i,
  input wire logic cca_done_i,
  input wire logic cca_idle_i,
  input wire logic tx_done_i,
  input wire logic phr_valid_i,
  input wire logic addr_match_i,
  input wire logic pll_lock_i,
  input wire logic [4:0] rx_info_i,
  input wire logic [BO_W-1:0] rand_i,
  output logic cca_start_o,
  output logic tx_start_o,
  output logic rx_enable_o,
  // Status and interrupts
  output logic [4:0] state_status_field_o,
  output logic [2:0] transaction_result_code_o,
  output logic [7:0] irq_o,
  input wire logic irq_ready_i
);
  localparam int TMO_BPSK = artx_pkg::ACK_WAIT_BPSK * SYM_CYCLES;
  localparam int TMO_OQPSK = artx_pkg::ACK_WAIT_OQPSK * SYM_CYCLES;
  localparam int CCA_CYC = artx_pkg::CCA_SYMBOLS * SYM_CYCLES;

  typedef struct packed {
    artx_pkg::artx_state_t st;
    logic from_off;
    logic [2:0] csma_cnt;
    logic [3:0] frame_cnt;
    logic [31:0] timer;
    logic trig_d;
    logic cca_start;
    logic tx_start;
    logic rx_en;
    logic [4:0] status;
    logic [2:0] result;
    logic [7:0] irq;
    logic [1:0] buf_cnt;
    artx_pkg::artx_evt_t [1:0] buf_q;
  } artx_reg_t;

  artx_reg_t r;
  artx_reg_t next_r;
  artx_pkg::artx_rx_t rx;
  artx_pkg::artx_evt_t ev;
  logic ev_valid;
  logic buf_ready;
  logic trig_rise;
  logic start;
  logic [31:0] bo_cycles;
  logic [BO_W-1:0] bo_mask;

  assign rx = artx_pkg::artx_rx_t'(rx_info_i);
  assign buf_ready = (r.buf_cnt != 2'd2);
  // RULE3: trigger edge or command
  assign trig_rise = sleep_trigger_pin_i & ~r.trig_d;
  assign start = trig_rise | (cmd_write_i && state_command_field_i == artx_pkg::CMD_TX_START);
  // RULE16: zero exponent, zero backoff
  assign bo_mask = (min_backoff_exponent_i == 4'h0) ? '0 :
    BO_W'((1 << min_backoff_exponent_i) - 1);
  assign bo_cycles = 32'(rand_i & bo_mask) * 32'(SYM_CYCLES * 20) + 32'(CCA_CYC);

  always_comb
  begin
    next_r = r;
    ev = '0;
    ev_valid = 1'b0;
    next_r.trig_d = sleep_trigger_pin_i;
    next_r.cca_start = 1'b0;
    next_r.tx_start = 1'b0;
    if (r.timer != 32'd0)
    begin
      next_r.timer = r.timer - 32'd1;
    end
    case (r.st)
      artx_pkg::ARTX_OFF:
      begin
        // RULE1: mode entry by command
        if (cmd_write_i && state_command_field_i == artx_pkg::CMD_AUTO_RETX)
        begin
          next_r.st = artx_pkg::ARTX_IDLE;
          next_r.status = artx_pkg::ST_RETX_IDLE;
          next_r.from_off = 1'b1;
        end
        else if (cmd_write_i && state_command_field_i == artx_pkg::CMD_AUTO_ACK)
        begin
          next_r.st = artx_pkg::ARTX_LISTEN;
          next_r.status = artx_pkg::ST_ACK_LISTEN;
          next_r.rx_en = 1'b1;
          next_r.from_off = 1'b1;
          // RULE23: invalid at procedure start
          next_r.result = artx_pkg::RES_INVALID;
        end
      end
      artx_pkg::ARTX_IDLE:
      begin
        if (cmd_write_i && state_command_field_i == artx_pkg::CMD_TRANSCEIVER_OFF_STATE)
        begin
          next_r.st = artx_pkg::ARTX_OFF;
          next_r.status = artx_pkg::ST_TRANSCEIVER_OFF_STATE;
        end
        else if (start && buf_ready)
        begin
          // RULE23: invalid at transaction start
          next_r.result = artx_pkg::RES_INVALID;
          // RULE18: busy through the transaction
          next_r.status = artx_pkg::ST_RETX_BUSY;
          // RULE24: clear both retry counters
          next_r.frame_cnt = 4'h0;
          next_r.csma_cnt = 3'h0;
          // RULE13: limit 7 skips channel access
          if (channel_access_retry_limit_i == artx_pkg::CSMA_NONE)
          begin
            next_r.st = artx_pkg::ARTX_TX;
            next_r.tx_start = 1'b1;
          end
          else
          begin
            // RULE4: channel access first
            next_r.st = artx_pkg::ARTX_CSMA;
            next_r.timer = bo_cycles;
          end
        end
      end
      artx_pkg::ARTX_CSMA:
      begin
        // RULE16: measurement starts after backoff
        if (r.timer == 32'(CCA_CYC))
        begin
          next_r.cca_start = 1'b1;
        end
        if (r.timer < 32'(CCA_CYC) && cca_done_i)
        begin
          if (cca_idle_i)
          begin
            // RULE4: idle channel, send frame
            next_r.st = artx_pkg::ARTX_TX;
            next_r.tx_start = 1'b1;
          end
          // RULE5: busy past limit fails
          else if (r.csma_cnt >= channel_access_retry_limit_i)
          begin
            next_r.st = artx_pkg::ARTX_IDLE;
            next_r.status = artx_pkg::ST_RETX_IDLE;
            ev_valid = 1'b1;
            ev.result = artx_pkg::RES_CHAN_BUSY;
          end
          else
          begin
            next_r.csma_cnt = r.csma_cnt + 3'h1;
            next_r.timer = bo_cycles;
          end
        end
      end
      artx_pkg::ARTX_TX:
      begin
        if (tx_done_i)
        begin
          // RULE6: reply request from octet one
          if (first_octet_i[artx_pkg::ACK_REQ_BIT])
          begin
            // RULE8: listen for reply
            next_r.st = artx_pkg::ARTX_WAIT;
            next_r.rx_en = 1'b1;
            // RULE17: waiting-for-reply code
            next_r.result = artx_pkg::RES_WAIT_REPLY;
            // RULE14: timeout by modulation
            // RULE15: counted in header symbols
            next_r.timer = bpsk_mode_i ? 32'(TMO_BPSK) : 32'(TMO_OQPSK);
          end
          else
          begin
            // RULE7: success without reply
            next_r.st = artx_pkg::ARTX_IDLE;
            next_r.status = artx_pkg::ST_RETX_IDLE;
            ev_valid = 1'b1;
            ev.result = artx_pkg::RES_SUCCESS;
          end
        end
      end
      artx_pkg::ARTX_WAIT, artx_pkg::ARTX_ACKRX:
      begin
        // RULE11: other frames ignored, buffer never written
        if (rx.valid && rx.is_ack && rx.fcs_ok && rx.seq_match)
        begin
          // RULE9: reply result with pending bit
          next_r.st = artx_pkg::ARTX_IDLE;
          next_r.status = artx_pkg::ST_RETX_IDLE;
          next_r.rx_en = 1'b0;
          ev_valid = 1'b1;
          ev.result = rx.frame_pending ? artx_pkg::RES_MORE_DATA : artx_pkg::RES_SUCCESS;
        end
        else if (phr_valid_i)
        begin
          next_r.st = artx_pkg::ARTX_ACKRX;
        end
        else if (r.timer == 32'd0)
        begin
          next_r.rx_en = 1'b0;
          // RULE10: retry or give up
          // RULE13: single attempt with limit 7
          if (r.frame_cnt >= frame_retry_limit_i ||
              channel_access_retry_limit_i == artx_pkg::CSMA_NONE)
          begin
            next_r.st = artx_pkg::ARTX_IDLE;
            next_r.status = artx_pkg::ST_RETX_IDLE;
            ev_valid = 1'b1;
            ev.result = artx_pkg::RES_NO_ACK;
          end
          else
          begin
            next_r.frame_cnt = r.frame_cnt + 4'h1;
            // RULE24: fresh channel access count
            next_r.csma_cnt = 3'h0;
            next_r.st = artx_pkg::ARTX_CSMA;
            next_r.timer = bo_cycles;
          end
        end
      end
      artx_pkg::ARTX_LISTEN:
      begin
        // RULE20: listen-mode events
        if (phr_valid_i)
        begin
          ev_valid = 1'b1;
          ev.irq[artx_pkg::IRQ_RX_START] = 1'b1;
          ev.result = r.result;
        end
        if (addr_match_i)
        begin
          ev_valid = 1'b1;
          ev.irq[artx_pkg::IRQ_AMI] = 1'b1;
          ev.result = r.result;
        end
        if (rx.valid && addr_match_i && rx.fcs_ok)
        begin
          ev.irq[artx_pkg::IRQ_TRX_END] = 1'b1;
          ev.result = artx_pkg::RES_SUCCESS;
        end
        if (cmd_write_i && state_command_field_i == artx_pkg::CMD_TRANSCEIVER_OFF_STATE)
        begin
          next_r.st = artx_pkg::ARTX_OFF;
          next_r.status = artx_pkg::ST_TRANSCEIVER_OFF_STATE;
          next_r.rx_en = 1'b0;
        end
      end
      default:
      begin
        next_r.st = artx_pkg::ARTX_OFF;
      end
    endcase
    // RULE22: retransmit ends always raise end event only
    if (ev_valid && r.st != artx_pkg::ARTX_LISTEN)
    begin
      ev.irq[artx_pkg::IRQ_TRX_END] = 1'b1;
    end
    // RULE21: lock interrupt after entry from off
    if (r.from_off && pll_lock_i && !ev_valid)
    begin
      ev_valid = 1'b1;
      ev.irq[artx_pkg::IRQ_PLL_LOCK] = 1'b1;
      ev.result = r.result;
      next_r.from_off = 1'b0;
    end
    // Two-entry event buffer
    if (ev_valid && buf_ready)
    begin
      next_r.buf_q[r.buf_cnt[0]] = ev;
      next_r.buf_cnt = r.buf_cnt + 2'd1;
      // RULE12: result valid from the interrupt
      if (ev.irq[artx_pkg::IRQ_TRX_END])
      begin
        next_r.result = ev.result;
      end
    end
    if (r.buf_cnt != 2'd0 && (irq_ready_i || r.irq == 8'h00))
    begin
      // RULE19: mask gates each source
      next_r.irq = r.buf_q[0].irq & irq_mask_i;
      next_r.buf_q[0] = r.buf_q[1];
      next_r.buf_cnt = next_r.buf_cnt - 2'd1;
      if (ev_valid && buf_ready)
      begin
        next_r.buf_q[r.buf_cnt - 2'd1] = ev;
      end
    end
    else if (irq_ready_i)
    begin
      next_r.irq = 8'h00;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r <= '{st: artx_pkg::ARTX_OFF, status: artx_pkg::ST_TRANSCEIVER_OFF_STATE,
             result: artx_pkg::RES_RESET, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign cca_start_o = r.cca_start;
  assign tx_start_o = r.tx_start;
  assign rx_enable_o = r.rx_en;
  assign state_status_field_o = r.status;
  assign transaction_result_code_o = r.result;
  assign irq_o = r.irq;
endmodule
`default_nettype wire

// ---- logic/artx_pkg.sv ----
// Package for the auto-retransmit transmit sequencer
package artx_pkg;
  // State command codes
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_TRANSCEIVER_OFF_STATE = 5'h08;
  localparam logic [4:0] CMD_AUTO_ACK = 5'h16;
  localparam logic [4:0] CMD_AUTO_RETX = 5'h19;
  // State status codes
  localparam logic [4:0] ST_TRANSCEIVER_OFF_STATE = 5'h08;
  localparam logic [4:0] ST_ACK_BUSY = 5'h11;
  localparam logic [4:0] ST_RETX_BUSY = 5'h12;
  localparam logic [4:0] ST_ACK_LISTEN = 5'h16;
  localparam logic [4:0] ST_RETX_IDLE = 5'h19;
  // Result codes
  localparam logic [2:0] RES_SUCCESS = 3'h0;
  localparam logic [2:0] RES_MORE_DATA = 3'h1;
  localparam logic [2:0] RES_WAIT_REPLY = 3'h2;
  localparam logic [2:0] RES_CHAN_BUSY = 3'h3;
  localparam logic [2:0] RES_NO_ACK = 3'h5;
  localparam logic [2:0] RES_INVALID = 3'h7;
  // Field positions and limits
  localparam int ACK_REQ_BIT = 5;
  localparam logic [2:0] CSMA_NONE = 3'h7;
  localparam int CCA_SYMBOLS = 8;
  localparam int ACK_WAIT_BPSK = 120;
  localparam int ACK_WAIT_OQPSK = 54;
  // Interrupt bit positions
  localparam int IRQ_PLL_LOCK = 0;
  localparam int IRQ_RX_START = 2;
  localparam int IRQ_TRX_END = 3;
  localparam int IRQ_CCA_DONE = 4;
  localparam int IRQ_AMI = 5;
  // Result reset value
  localparam logic [2:0] RES_RESET = 3'h0;

  typedef enum logic [2:0] {
    ARTX_OFF = 3'b000,
    ARTX_IDLE = 3'b001,
    ARTX_CSMA = 3'b011,
    ARTX_TX = 3'b010,
    ARTX_WAIT = 3'b110,
    ARTX_ACKRX = 3'b111,
    ARTX_LISTEN = 3'b101
  } artx_state_t;

  // Received reply report from the receiver
  typedef struct packed {
    logic valid;
    logic is_ack;
    logic fcs_ok;
    logic seq_match;
    logic frame_pending;
  } artx_rx_t;

  // Buffered result word
  typedef struct packed {
    logic [2:0] result;
    logic [7:0] irq;
  } artx_evt_t;
endpackage

// ---- testbench/artx_sequencer_assertions.sv ----
// Port checks for the retransmit sequencer
`timescale 1ns/1ps
`default_nettype none
module artx_sequencer_assertions #(
  parameter int SYM_CYCLES = 320
) (
  // Host side
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] state_command_field_i,
  input wire logic cmd_write_i,
  input wire logic [2:0] channel_access_retry_limit_i,
  input wire logic bpsk_mode_i,
  input wire logic [7:0] irq_mask_i,
  // Radio side and status
  input wire logic cca_done_i,
  input wire logic cca_idle_i,
  input wire logic [4:0] rx_info_i,
  input wire logic cca_start_o,
  input wire logic tx_start_o,
  input wire logic rx_enable_o,
  input wire logic [4:0] state_status_field_o,
  input wire logic [2:0] transaction_result_code_o,
  input wire logic [7:0] irq_o
);
  logic busy;
  logic [15:0] wait_cnt;
  assign busy = state_status_field_o == artx_pkg::ST_RETX_BUSY;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Listening time
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      wait_cnt <= 16'h0000;
    else
      wait_cnt <= rx_enable_o ? wait_cnt + 16'h0001 : 16'h0000;
  sequence s_clear;
    busy && cca_done_i && cca_idle_i;
  endsequence
  property p_start;
    state_status_field_o == artx_pkg::ST_RETX_IDLE && cmd_write_i && state_command_field_i == artx_pkg::CMD_TX_START
      |=> busy && transaction_result_code_o == artx_pkg::RES_INVALID;
  endproperty
  a_start: assert property (p_start) else $error("start left result valid");
  property p_quiet;
    busy |-> (irq_o & 8'h34) == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("suppressed interrupt raised");
  property p_wait;
    $rose(rx_enable_o) && busy |-> ##[0:1] transaction_result_code_o == artx_pkg::RES_WAIT_REPLY;
  endproperty
  a_wait: assert property (p_wait) else $error("no waiting code while listening");
  property p_irq;
    $fell(busy) && irq_mask_i[artx_pkg::IRQ_TRX_END] |-> ##[1:3] irq_o[artx_pkg::IRQ_TRX_END];
  endproperty
  a_irq: assert property (p_irq) else $error("end interrupt missing");
  property p_direct;
    channel_access_retry_limit_i == artx_pkg::CSMA_NONE |-> !cca_start_o;
  endproperty
  a_direct: assert property (p_direct) else $error("channel access in direct mode");
  property p_send;
    s_clear |-> ##[1:2] tx_start_o;
  endproperty
  a_send: assert property (p_send) else $error("idle channel not followed by send");
  property p_reply;
    rx_enable_o && rx_info_i[4:1] == 4'hf |-> ##[1:3] transaction_result_code_o inside {3'h0, 3'h1};
  endproperty
  a_reply: assert property (p_reply) else $error("valid reply not reported");
  property p_timeout;
    rx_enable_o |-> wait_cnt <= 16'((bpsk_mode_i ? artx_pkg::ACK_WAIT_BPSK : artx_pkg::ACK_WAIT_OQPSK)
      * SYM_CYCLES + 8);
  endproperty
  a_timeout: assert property (p_timeout) else $error("reply wait too long");
endmodule
bind artx_sequencer artx_sequencer_assertions #(.SYM_CYCLES(SYM_CYCLES)) u_check (
  .mclk_i, .rst_n_i, .state_command_field_i, .cmd_write_i, .channel_access_retry_limit_i, .bpsk_mode_i,
  .irq_mask_i, .cca_done_i, .cca_idle_i, .rx_info_i, .cca_start_o, .tx_start_o, .rx_enable_o,
  .state_status_field_o, .transaction_result_code_o, .irq_o
);
`default_nettype wire

// ---- testbench/artx_radio_model.sv ----
// Radio model: channel check, frame send, replies
`timescale 1ns/1ps
`default_nettype none
module artx_radio_model #(
  parameter int SYM_CYCLES = 4
) (
  // Requests and knobs
  input wire logic mclk_i,
  input wire logic cca_start_i,
  input wire logic tx_start_i,
  input wire logic chan_busy_i,
  input wire logic [1:0] reply_mode_i,
  input wire logic pending_i,
  // Answers
  output logic cca_done_o,
  output logic cca_idle_o,
  output logic tx_done_o,
  output logic frame_o,
  output logic [4:0] rx_info_o
);
  initial
    {cca_done_o, cca_idle_o, tx_done_o, frame_o, rx_info_o} = 9'h000;
  always @(posedge mclk_i)
  begin
    #2;
    if (cca_start_i === 1'h1)
    begin
      repeat (8 * SYM_CYCLES - 1) @(posedge mclk_i);
      #2 cca_done_o = 1'h1;
      cca_idle_o = !chan_busy_i;
      @(posedge mclk_i);
      #2 cca_done_o = 1'h0;
      cca_idle_o = chan_busy_i;
    end
  end
  always @(posedge mclk_i)
  begin
    #2;
    if (tx_start_i === 1'h1)
    begin
      repeat (10) @(posedge mclk_i);
      #2 tx_done_o = 1'h1;
      @(posedge mclk_i);
      #2 tx_done_o = 1'h0;
      if (reply_mode_i != 2'h0)
      begin
        repeat (20) @(posedge mclk_i);
        #2 rx_info_o = 5'h16;
        frame_o = 1'h1;
        @(posedge mclk_i);
        #2 rx_info_o = {2'h3, reply_mode_i == 2'h1, 1'h1, pending_i};
        frame_o = 1'h0;
        @(posedge mclk_i);
        #2 rx_info_o = {1'h0, ~rx_info_o[3:0]};
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/artx_sequencer_test.sv ----
// Random and corner bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module artx_sequencer_test;
  logic mclk_i = 1'h0, rst_n_i = 1'h0, cmd_write_i = 1'h0, sleep_trigger_pin_i = 1'h0, bpsk_mode_i = 1'h0;
  logic pll_lock_i = 1'h0, irq_ready_i = 1'h0, chan_busy = 1'h0, pending = 1'h0, frame, hdr = 1'h0;
  logic [4:0] state_command_field_i = 5'h00, rx_info_i, state_status_field_o;
  logic [2:0] channel_access_retry_limit_i = 3'h0, transaction_result_code_o;
  logic [3:0] frame_retry_limit_i = 4'h0, min_backoff_exponent_i = 4'h0;
  logic [7:0] irq_mask_i = 8'hff, first_octet_i = 8'h00, rand_i = 8'h00, irq_o;
  logic [1:0] reply_mode = 2'h0;
  logic cca_done_i, cca_idle_i, tx_done_i, cca_start_o, tx_start_o, rx_enable_o;
  int mismatches = 0, num_checks = 0, seed = 32'h19117d10, cycles = 0, ntx = 0, ncca = 0, mode;
  wire logic phr_valid_i = frame | hdr;
  wire logic addr_match_i = frame | hdr;
  artx_sequencer #(.SYM_CYCLES(4), .BO_W(8)) dut (
    .mclk_i, .rst_n_i, .state_command_field_i, .cmd_write_i, .sleep_trigger_pin_i,
    .channel_access_retry_limit_i, .frame_retry_limit_i, .min_backoff_exponent_i, .bpsk_mode_i,
    .irq_mask_i, .first_octet_i, .cca_done_i, .cca_idle_i, .tx_done_i, .phr_valid_i, .addr_match_i,
    .pll_lock_i, .rx_info_i, .rand_i, .cca_start_o, .tx_start_o, .rx_enable_o,
    .state_status_field_o, .transaction_result_code_o, .irq_o, .irq_ready_i
  );
  artx_radio_model #(.SYM_CYCLES(4)) radio (
    .mclk_i, .cca_start_i(cca_start_o), .tx_start_i(tx_start_o), .chan_busy_i(chan_busy),
    .reply_mode_i(reply_mode), .pending_i(pending), .cca_done_o(cca_done_i), .cca_idle_o(cca_idle_i),
    .tx_done_o(tx_done_i), .frame_o(frame), .rx_info_o(rx_info_i)
  );
  initial
    forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cycles++;
    #5 rand_i = 8'($random(seed));
    if (cycles == 90000)
    begin
      mismatches++;
      finish_test();
    end
  end
  always @(negedge mclk_i)
  begin
    ntx += int'(tx_start_o === 1'h1);
    ncca += int'(cca_start_o === 1'h1);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask
  function automatic int sends();
    if (mode == 3)
      return 0;
    if (mode < 2 || channel_access_retry_limit_i == artx_pkg::CSMA_NONE)
      return 1;
    return int'(frame_retry_limit_i) + 1;
  endfunction
  function automatic logic [7:0] code();
    case (mode)
      0: return 8'(artx_pkg::RES_SUCCESS);
      1: return 8'(pending ? artx_pkg::RES_MORE_DATA : artx_pkg::RES_SUCCESS);
      3: return 8'(artx_pkg::RES_CHAN_BUSY);
      default: return 8'(artx_pkg::RES_NO_ACK);
    endcase
  endfunction
  task automatic run(input logic by_pin);
    int n;
    int want_cca;
    n = 0;
    ntx = 0;
    ncca = 0;
    sleep_trigger_pin_i = by_pin;
    cmd_write_i = !by_pin;
    step(1);
    {sleep_trigger_pin_i, cmd_write_i} = 2'h0;
    while (state_status_field_o !== artx_pkg::ST_RETX_BUSY && n < 20004)
    begin
      step(1);
      n = n < 4 ? n + 1 : 20004;
      n = state_status_field_o === artx_pkg::ST_RETX_BUSY && n < 5 ? 5 : n;
    end
    check(8'(state_status_field_o), 8'(artx_pkg::ST_RETX_BUSY));
    check(8'(transaction_result_code_o), 8'(artx_pkg::RES_INVALID));
    while (state_status_field_o === artx_pkg::ST_RETX_BUSY && n < 20000)
    begin
      step(1);
      n++;
    end
    step(2);
    check(8'(transaction_result_code_o), code());
    check(8'(state_status_field_o), 8'(artx_pkg::ST_RETX_IDLE));
    check(8'(ntx), 8'(sends()));
    want_cca = mode == 3 ? int'(channel_access_retry_limit_i) + 1 : sends();
    want_cca = channel_access_retry_limit_i == artx_pkg::CSMA_NONE ? 0 : want_cca;
    check(8'(ncca), 8'(want_cca));
    check(irq_o, {4'h0, irq_mask_i[3], 3'h0});
    irq_ready_i = 1'h1;
    step(1);
    irq_ready_i = 1'h0;
  endtask
  initial
  begin
    state_command_field_i = artx_pkg::CMD_AUTO_RETX;
    step(11);
    check(8'(transaction_result_code_o), 8'(artx_pkg::RES_RESET));
    step(1);
    rst_n_i = 1'h1;
    cmd_write_i = 1'h1;
    step(1);
    {cmd_write_i, pll_lock_i} = 2'h1;
    step(1);
    pll_lock_i = 1'h0;
    check(8'(state_status_field_o), 8'(artx_pkg::ST_RETX_IDLE));
    step(2);
    check(irq_o, 8'h01);
    {irq_ready_i, state_command_field_i} = {1'h1, artx_pkg::CMD_TX_START};
    step(1);
    irq_ready_i = 1'h0;
    for (int i = 0; i < 12; i++)
    begin
      mode = i == 10 ? 2 : i % 5;
      channel_access_retry_limit_i = i == 10 ? artx_pkg::CSMA_NONE : 3'($random(seed) & 3);
      frame_retry_limit_i = 4'($random(seed) & 3);
      min_backoff_exponent_i = 4'($random(seed) & 1);
      {bpsk_mode_i, pending} = 2'($random(seed));
      irq_mask_i = i == 11 ? 8'hf7 : 8'hff;
      first_octet_i = 8'($random(seed));
      first_octet_i[artx_pkg::ACK_REQ_BIT] = mode != 0;
      chan_busy = mode == 3;
      reply_mode = mode == 1 ? 2'h1 : mode == 4 ? 2'h2 : 2'h0;
      run(1'($random(seed)));
    end
    // Listen mode entered through off
    {cmd_write_i, state_command_field_i} = {1'h1, artx_pkg::CMD_TRANSCEIVER_OFF_STATE};
    step(1);
    check(8'(state_status_field_o), 8'(artx_pkg::ST_TRANSCEIVER_OFF_STATE));
    state_command_field_i = artx_pkg::CMD_AUTO_ACK;
    step(1);
    cmd_write_i = 1'h0;
    check(8'(state_status_field_o), 8'(artx_pkg::ST_ACK_LISTEN));
    check(8'(transaction_result_code_o), 8'(artx_pkg::RES_INVALID));
    hdr = 1'h1;
    step(1);
    hdr = 1'h0;
    step(2);
    check(irq_o, 8'h24 & irq_mask_i);
    finish_test();
  end
endmodule
`default_nettype wire
